//--- sow_pkg.sv
/*
 * sow_pkg: constants and types shared by the system options and periodic
 * wakeup register bank.
 * assumes a single 200 MHz bus clock; register access is a byte-wide
 * request carried by sow_req_t.
 */
package sow_pkg;

   // register indices on the register request port
   localparam logic [2:0] IDX_DEBUG_FORCE_RESET = 3'h0;
   localparam logic [2:0] IDX_SYSTEM_OPTIONS = 3'h1;
   localparam logic [2:0] IDX_PART_NUMBER_HIGH = 3'h2;
   localparam logic [2:0] IDX_PART_NUMBER_LOW = 3'h3;
   localparam logic [2:0] IDX_WAKEUP_STATUS_CONTROL = 3'h4;

   // debug_force_reset fields
   localparam int DBG_FORCED_RESET_BIT = 0;
   localparam logic [7:0] DBG_FORCE_RESET_READ = 8'h00;

   // system_options fields
   localparam int OPT_WATCHDOG_ENABLE = 7;
   localparam int OPT_WATCHDOG_TIMEOUT_SELECT = 6;
   localparam int OPT_STOP_ALLOW = 5;
   localparam int OPT_DEBUG_PIN_ENABLE = 1;
   localparam logic [7:0] OPT_IMPL_MASK = 8'he2;
   localparam logic [7:0] OPT_RESET = 8'hc2;

   // part identification, value arbitrary
   localparam logic [11:0] PART_NUMBER_FIELD = 12'h5a3;

   // wakeup_status_control fields
   localparam int WKP_FLAG = 7;
   localparam int WKP_ACKNOWLEDGE = 6;
   localparam int WKP_CLOCK_SELECT = 5;
   localparam int WKP_INTERRUPT_ENABLE = 4;
   localparam int WKP_PERIOD_LSB = 0;
   localparam logic [7:0] WKP_RESET = 8'h00;

   // timing
   localparam int CLK_MHZ = 200;
   localparam int T_WAKEUP_OSC_US = 1150;
   localparam int WAKEUP_OSC_CYC = T_WAKEUP_OSC_US * CLK_MHZ;
   localparam int WKP_INT_BASE_TICKS = 8;
   localparam int WDOG_SHORT_CYC = 2 ** 13;
   localparam int WDOG_LONG_CYC = 2 ** 18;

   typedef struct packed {
      logic wr;
      logic rd;
      logic fromDebug;
      logic [2:0] idx;
      logic [7:0] wdata;
   } sow_req_t;

   typedef struct packed {
      logic watchdogEnable;
      logic watchdogTimeoutSelect;
      logic stopAllow;
      logic debugPinEnable;
   } sow_opt_t;

endpackage : sow_pkg

//--- sow_sync.sv
/*
 * sow_sync: three-stage synchroniser for a pin input.
 * assumes the pin is asynchronous to clk; the output moves only when the
 * second and third stages agree.
 */
`timescale 1ns/1ps
module sow_sync
   import sow_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic pinIn,
   output logic pinOut
);

   logic stage1_q;
   logic stage2_q;
   logic stage3_q;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage1_q <= 1'b0;
         stage2_q <= 1'b0;
         stage3_q <= 1'b0;
      end else begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pinOut <= 1'b0;
      end else if (stage2_q == stage3_q) begin
         pinOut <= stage3_q;
      end
   end

endmodule : sow_sync

//--- sow_system_options.sv
/*
 * sow_system_options: system configuration bank with debug forced reset,
 * write-once options, part identification and periodic wakeup timer.
 * assumes the register request port is driven by the bus clock domain and
 * that the reset controller acts on the reset request pulses.
 */
// Function
// - forced-reset register always reads zero
// - user-program writes to forced reset ignored
// - debug writing bit0 one forces reset
// - options accept only first write after reset
// - options bits 3 and 2 read zero
// - watchdog enable resets one, gates watchdog
// - timeout select: one long, zero short
// - stop while disallowed forces illegal-opcode reset
// - debug pin enable selects pin function
// - fixed read-only 12-bit part number
// - wakeup flag read-only, set on timeout
// - acknowledge one clears flag, reads zero
// - clock select: internal or external source
// - interrupt enable readable and writable
// - internal periods 9.2 ms doubling upward
// - external: code zero off, else divide
// - internal oscillator runs independently
// - wakeup register bit 3 reads zero
// - forced reset reports no reset cause
`timescale 1ns/1ps
module sow_system_options
   import sow_pkg::*;
#(
   parameter int WAKEUP_OSC_CYCLES = WAKEUP_OSC_CYC,
   parameter int WDOG_SHORT_CYCLES = WDOG_SHORT_CYC,
   parameter int WDOG_LONG_CYCLES = WDOG_LONG_CYC
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire sow_req_t busReq,
   output logic [7:0] busRdata,
   input wire logic watchdogService,
   input wire logic stopExec,
   input wire logic extClkPin,
   input wire logic portPinData,
   output logic watchdogResetReq,
   output logic illegalOpResetReq,
   output logic stopGrant,
   output logic debugResetReq,
   output logic resetCauseQuiet,
   output logic wakeupIrq,
   output logic wakeupPulse,
   output logic debugPinFunction,
   output logic portPinOut,
   output logic portPinOe_n
);

   localparam logic [31:0] OSC_LAST = 32'(WAKEUP_OSC_CYCLES - 1);
   localparam logic [17:0] WD_SHORT_LAST = 18'(WDOG_SHORT_CYCLES - 1);
   localparam logic [17:0] WD_LONG_LAST = 18'(WDOG_LONG_CYCLES - 1);

   sow_opt_t opt_q;
   logic optLocked_q;
   logic wkpFlag_q;
   logic wkpClockSelect_q;
   logic wkpIrqEnable_q;
   logic [2:0] wkpPeriod_q;
   logic [31:0] oscCnt_q;
   logic oscTick_q;
   logic [15:0] wkpCnt_q;
   logic [15:0] wkpLast;
   logic wkpEvent;
   logic wkpOff;
   logic wkpTimeout;
   logic extSync;
   logic extPrev_q;
   logic extRise;
   logic [17:0] wdCnt_q;
   logic [17:0] wdLast;
   logic optWrite;
   logic wkpWrite;
   logic dbgWrite;
   logic [7:0] optRead;
   logic [7:0] wkpRead;
   logic [7:0] rdata_d;

   assign optWrite = busReq.wr && busReq.idx == IDX_SYSTEM_OPTIONS;
   assign wkpWrite = busReq.wr && busReq.idx == IDX_WAKEUP_STATUS_CONTROL;
   assign dbgWrite = busReq.wr && busReq.fromDebug &&
                     busReq.idx == IDX_DEBUG_FORCE_RESET;

   // forced reset request from the debug host

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         debugResetReq <= 1'b0;
      end else begin
         debugResetReq <= dbgWrite && busReq.wdata[DBG_FORCED_RESET_BIT];
      end
   end

   assign resetCauseQuiet = debugResetReq;

   // write-once system options

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         optLocked_q <= 1'b0;
      end else if (optWrite) begin
         optLocked_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         opt_q.watchdogEnable <= OPT_RESET[OPT_WATCHDOG_ENABLE];
         opt_q.watchdogTimeoutSelect <=
            OPT_RESET[OPT_WATCHDOG_TIMEOUT_SELECT];
         opt_q.stopAllow <= OPT_RESET[OPT_STOP_ALLOW];
         opt_q.debugPinEnable <= OPT_RESET[OPT_DEBUG_PIN_ENABLE];
      end else if (optWrite && !optLocked_q) begin
         opt_q.watchdogEnable <= busReq.wdata[OPT_WATCHDOG_ENABLE];
         opt_q.watchdogTimeoutSelect <=
            busReq.wdata[OPT_WATCHDOG_TIMEOUT_SELECT];
         opt_q.stopAllow <= busReq.wdata[OPT_STOP_ALLOW];
         opt_q.debugPinEnable <= busReq.wdata[OPT_DEBUG_PIN_ENABLE];
      end
   end

   // watchdog

   assign wdLast = opt_q.watchdogTimeoutSelect ? WD_LONG_LAST
                                               : WD_SHORT_LAST;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wdCnt_q <= 18'h00000;
         watchdogResetReq <= 1'b0;
      end else if (!opt_q.watchdogEnable || watchdogService) begin
         wdCnt_q <= 18'h00000;
         watchdogResetReq <= 1'b0;
      end else if (wdCnt_q >= wdLast) begin
         // shortened limit after a write is caught by >=
         wdCnt_q <= 18'h00000;
         watchdogResetReq <= 1'b1;
      end else begin
         wdCnt_q <= wdCnt_q + 18'h00001;
         watchdogResetReq <= 1'b0;
      end
   end

   // stop instruction handling

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         illegalOpResetReq <= 1'b0;
         stopGrant <= 1'b0;
      end else begin
         illegalOpResetReq <= stopExec && !opt_q.stopAllow;
         stopGrant <= stopExec && opt_q.stopAllow;
      end
   end

   // shared debug / output-only pin

   assign debugPinFunction = opt_q.debugPinEnable;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         portPinOut <= 1'b0;
         portPinOe_n <= 1'b1;
      end else begin
         portPinOut <= portPinData;
         portPinOe_n <= opt_q.debugPinEnable;
      end
   end

   // internal wakeup oscillator

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         oscCnt_q <= 32'h00000000;
         oscTick_q <= 1'b0;
      end else if (oscCnt_q >= OSC_LAST) begin
         oscCnt_q <= 32'h00000000;
         oscTick_q <= 1'b1;
      end else begin
         oscCnt_q <= oscCnt_q + 32'h00000001;
         oscTick_q <= 1'b0;
      end
   end

   // external wakeup clock

   sow_sync extSyncInst (
      .clk(clk),
      .reset_n(reset_n),
      .pinIn(extClkPin),
      .pinOut(extSync)
   );

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         extPrev_q <= 1'b0;
      end else begin
         extPrev_q <= extSync;
      end
   end

   assign extRise = extSync && !extPrev_q;

   // wakeup period counter

   assign wkpEvent = wkpClockSelect_q ? extRise : oscTick_q;
   assign wkpOff = wkpClockSelect_q && wkpPeriod_q == 3'h0;

   always_comb begin
      wkpLast = 16'h0000;
      if (wkpClockSelect_q) begin
         case (wkpPeriod_q)
            3'h1: wkpLast = 16'h00ff;
            3'h2: wkpLast = 16'h03ff;
            3'h3: wkpLast = 16'h07ff;
            3'h4: wkpLast = 16'h0fff;
            3'h5: wkpLast = 16'h1fff;
            3'h6: wkpLast = 16'h3fff;
            3'h7: wkpLast = 16'h7fff;
            default: wkpLast = 16'h0000;
         endcase
      end else begin
         wkpLast = 16'((WKP_INT_BASE_TICKS << wkpPeriod_q) - 1);
      end
   end

   assign wkpTimeout = wkpEvent && !wkpOff && wkpCnt_q >= wkpLast;

   // restart on any control write so a new period starts clean
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wkpCnt_q <= 16'h0000;
      end else if (wkpWrite || wkpOff) begin
         wkpCnt_q <= 16'h0000;
      end else if (wkpTimeout) begin
         wkpCnt_q <= 16'h0000;
      end else if (wkpEvent) begin
         wkpCnt_q <= wkpCnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wakeupPulse <= 1'b0;
      end else begin
         wakeupPulse <= wkpTimeout;
      end
   end

   // wakeup status and control

   // timeout sets flag, set beats clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wkpFlag_q <= WKP_RESET[WKP_FLAG];
      end else if (wkpTimeout) begin
         // a timeout in the cycle of an ack still counts
         wkpFlag_q <= 1'b1;
      end else if (wkpWrite && busReq.wdata[WKP_ACKNOWLEDGE]) begin
         wkpFlag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wkpClockSelect_q <= WKP_RESET[WKP_CLOCK_SELECT];
         wkpIrqEnable_q <= WKP_RESET[WKP_INTERRUPT_ENABLE];
         wkpPeriod_q <= WKP_RESET[WKP_PERIOD_LSB +: 3];
      end else if (wkpWrite) begin
         wkpClockSelect_q <= busReq.wdata[WKP_CLOCK_SELECT];
         wkpIrqEnable_q <= busReq.wdata[WKP_INTERRUPT_ENABLE];
         wkpPeriod_q <= busReq.wdata[WKP_PERIOD_LSB +: 3];
      end
   end

   assign wakeupIrq = wkpFlag_q && wkpIrqEnable_q;

   // read path

   always_comb begin
      optRead = 8'h00;
      optRead[OPT_WATCHDOG_ENABLE] = opt_q.watchdogEnable;
      optRead[OPT_WATCHDOG_TIMEOUT_SELECT] = opt_q.watchdogTimeoutSelect;
      optRead[OPT_STOP_ALLOW] = opt_q.stopAllow;
      optRead[OPT_DEBUG_PIN_ENABLE] = opt_q.debugPinEnable;
      optRead = optRead & OPT_IMPL_MASK;
   end

   always_comb begin
      // bit 3 and acknowledge read zero
      wkpRead = 8'h00;
      wkpRead[WKP_FLAG] = wkpFlag_q;
      wkpRead[WKP_CLOCK_SELECT] = wkpClockSelect_q;
      wkpRead[WKP_INTERRUPT_ENABLE] = wkpIrqEnable_q;
      wkpRead[WKP_PERIOD_LSB +: 3] = wkpPeriod_q;
   end

   always_comb begin
      case (busReq.idx)
         IDX_DEBUG_FORCE_RESET: rdata_d = DBG_FORCE_RESET_READ;
         IDX_SYSTEM_OPTIONS: rdata_d = optRead;
         IDX_PART_NUMBER_HIGH: rdata_d = {4'h0, PART_NUMBER_FIELD[11:8]};
         IDX_PART_NUMBER_LOW: rdata_d = PART_NUMBER_FIELD[7:0];
         IDX_WAKEUP_STATUS_CONTROL: rdata_d = wkpRead;
         default: rdata_d = 8'h00;
      endcase
   end

   // read data held until the next read
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         busRdata <= 8'h00;
      end else if (busReq.rd) begin
         busRdata <= rdata_d;
      end
   end

endmodule : sow_system_options

//--- sow_checker_properties.sv
/*
 * sow_checker: concurrent checks on the system options and wakeup bank.
 * assumes one clock domain, synchronous active-low reset, bound by name.
 */
`timescale 1ns/1ps
module sow_checker
   import sow_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire sow_req_t busReq,
   input wire logic [7:0] busRdata,
   input wire logic stopExec,
   input wire logic illegalOpResetReq,
   input wire logic stopGrant,
   input wire logic debugResetReq,
   input wire logic resetCauseQuiet,
   input wire logic wakeupIrq,
   input wire logic debugPinFunction,
   input wire logic portPinOe_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   logic optLock_q;

   // options lock as software sees it: any write consumes it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         optLock_q <= 1'b0;
      end else if (busReq.wr && busReq.idx == IDX_SYSTEM_OPTIONS) begin
         optLock_q <= 1'b1;
      end
   end

   sequence sDbgSet;
      busReq.wr && busReq.fromDebug && busReq.idx == IDX_DEBUG_FORCE_RESET &&
         busReq.wdata[DBG_FORCED_RESET_BIT];
   endsequence
   sequence sUserForce;
      busReq.wr && !busReq.fromDebug && busReq.idx == IDX_DEBUG_FORCE_RESET;
   endsequence
   sequence sRead(logic [2:0] i);
      busReq.rd && busReq.idx == i;
   endsequence
   sequence sOptRewrite;
      optLock_q && busReq.wr && busReq.idx == IDX_SYSTEM_OPTIONS;
   endsequence

   a_dbg_reset_fires: assert property (
      sDbgSet |=> debugResetReq)
      else $error("debug forced reset did not pulse");
   a_user_force_ignored: assert property (
      sUserForce |=> !debugResetReq)
      else $error("user write forced a reset");
   a_dbg_reset_cause: assert property (
      debugResetReq |-> $past(busReq.wr && busReq.fromDebug &&
         busReq.idx == IDX_DEBUG_FORCE_RESET &&
         busReq.wdata[DBG_FORCED_RESET_BIT]))
      else $error("forced reset without a debug write");
   a_cause_stays_quiet: assert property (
      resetCauseQuiet == debugResetReq)
      else $error("reset cause quiet differs from forced reset");
   a_force_reads_zero: assert property (
      sRead(IDX_DEBUG_FORCE_RESET) |=> busRdata == DBG_FORCE_RESET_READ)
      else $error("forced reset register read nonzero");
   a_opt_unimpl_zero: assert property (
      sRead(IDX_SYSTEM_OPTIONS) |=> busRdata[3:2] == 2'h0)
      else $error("options bits 3:2 not zero");
   a_opt_write_once: assert property (
      sOptRewrite |=> $stable(debugPinFunction))
      else $error("options changed after the first write");
   a_wkp_fixed_zero: assert property (
      sRead(IDX_WAKEUP_STATUS_CONTROL) |=>
         busRdata[WKP_ACKNOWLEDGE] == 1'b0 && busRdata[3] == 1'b0)
      else $error("wakeup ack or bit 3 read nonzero");
   a_part_high_value: assert property (
      sRead(IDX_PART_NUMBER_HIGH) |=>
         busRdata == {4'h0, PART_NUMBER_FIELD[11:8]})
      else $error("part number high wrong");
   a_part_low_value: assert property (
      sRead(IDX_PART_NUMBER_LOW) |=> busRdata == PART_NUMBER_FIELD[7:0])
      else $error("part number low wrong");
   a_stop_one_outcome: assert property (
      stopExec |=> $onehot({illegalOpResetReq, stopGrant}))
      else $error("stop gave no single outcome");
   a_irq_masked_off: assert property (
      busReq.wr && busReq.idx == IDX_WAKEUP_STATUS_CONTROL &&
         !busReq.wdata[WKP_INTERRUPT_ENABLE] |=> !wakeupIrq)
      else $error("wakeup irq while disabled");
   a_pin_not_driven: assert property (
      debugPinFunction |-> portPinOe_n)
      else $error("port pin driven in debug mode");
   a_pin_oe_follows: assert property (
      portPinOe_n == $past(debugPinFunction))
      else $error("port pin enable does not follow option");
endmodule : sow_checker

bind sow_system_options sow_checker i_chk (.clk(clk), .reset_n(reset_n),
   .busReq(busReq), .busRdata(busRdata), .stopExec(stopExec),
   .illegalOpResetReq(illegalOpResetReq), .stopGrant(stopGrant),
   .debugResetReq(debugResetReq), .resetCauseQuiet(resetCauseQuiet),
   .wakeupIrq(wakeupIrq), .debugPinFunction(debugPinFunction),
   .portPinOe_n(portPinOe_n));

//--- sow_ext_source.sv
/*
 * sow_ext_source: external wakeup clock source on the far side.
 * assumes a free period of 20 ns, unrelated to the bus clock phase.
 */
`timescale 1ns/1ps
module sow_ext_source (
   input wire logic run,
   output logic extClk
);
   initial extClk = 1'b0;
   // stands low while not running
   always begin
      #10;
      extClk = run ? ~extClk : 1'b0;
   end
endmodule : sow_ext_source

//--- system_options_and_periodic_wakeup_bench.sv
/*
 * bench: register-call tests for the options and wakeup bank.
 * assumes shortened timer parameters and the external source model.
 */
`timescale 1ns/1ps
module system_options_and_periodic_wakeup_bench;
   import sow_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   sow_req_t busReq = '0;
   logic svc = 1'b0;
   logic stopExec = 1'b0;
   logic portPinData = 1'b0;
   logic run = 1'b0;
   logic extClkPin, wdogReq, illOp, grant, dbgReq, quiet, irq, wkPulse;
   logic pinFn, pinOut, pinOe_n;
   logic [7:0] busRdata;
   int errorCnt = 0;
   int checks = 0;
   int cyc = 0;
   int n;

   always #2.5 clk = ~clk;

   sow_system_options #(.WAKEUP_OSC_CYCLES(4), .WDOG_SHORT_CYCLES(16),
      .WDOG_LONG_CYCLES(64)) i_dut (.clk(clk), .reset_n(reset_n),
      .busReq(busReq), .busRdata(busRdata), .watchdogService(svc),
      .stopExec(stopExec), .extClkPin(extClkPin),
      .portPinData(portPinData), .watchdogResetReq(wdogReq),
      .illegalOpResetReq(illOp), .stopGrant(grant),
      .debugResetReq(dbgReq), .resetCauseQuiet(quiet), .wakeupIrq(irq),
      .wakeupPulse(wkPulse), .debugPinFunction(pinFn),
      .portPinOut(pinOut), .portPinOe_n(pinOe_n));
   sow_ext_source i_ext (.run(run), .extClk(extClkPin));

   task results;
      $display("errors %0d checks %0d", errorCnt, checks);
      if (errorCnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task wr(input logic [2:0] idx, input logic [7:0] d, input logic dbg);
      @(posedge clk);
      busReq <= '{wr: 1'b1, rd: 1'b0, fromDebug: dbg, idx: idx, wdata: d};
      @(posedge clk);
      busReq.wr <= 1'b0;
      #1;
   endtask : wr

   task rd(input logic [2:0] idx, input logic [7:0] exp, input string nm);
      @(posedge clk);
      busReq <= '{wr: 1'b0, rd: 1'b1, fromDebug: 1'b0, idx: idx, wdata: 8'h00};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 chk(nm, exp, busRdata);
   endtask : rd

   // bounded wait for a watchdog or wakeup pulse
   task cnt(input logic wd, output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (!(wd ? wdogReq : wkPulse) && k < 3000);
      #1;
   endtask : cnt

   task pulse(input logic isStop);
      @(posedge clk);
      if (isStop) stopExec <= 1'b1; else svc <= 1'b1;
      @(posedge clk);
      stopExec <= 1'b0;
      svc <= 1'b0;
      #1;
   endtask : pulse

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errorCnt++;
         results();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(3'h4, 8'h00, "wakeup reset");
      rd(3'h1, 8'hc2, "options reset");
      rd(3'h0, 8'h00, "force reset read");
      rd(3'h2, {4'h0, PART_NUMBER_FIELD[11:8]}, "part high");
      rd(3'h3, PART_NUMBER_FIELD[7:0], "part low");
      rd(3'h7, 8'h00, "unmapped");
      chk("pin function", 8'h01, pinFn);
      wr(3'h0, 8'h01, 1'b0);
      chk("user force", 8'h00, dbgReq);
      pulse(1'b1);
      chk("illegal stop", 8'h01, illOp);
      pulse(1'b0);
      cnt(1'b1, n);
      chk("long watchdog", 8'h01, n >= 60 && n <= 68);
      wr(3'h1, 8'ha2, 1'b0);
      rd(3'h1, 8'ha2, "options first");
      wr(3'h1, 8'h00, 1'b1);
      rd(3'h1, 8'ha2, "options locked");
      pulse(1'b0);
      cnt(1'b1, n);
      chk("short watchdog", 8'h01, n >= 12 && n <= 20);
      pulse(1'b1);
      chk("stop grant", 8'h01, grant);
      for (int k = 0; k < 3; k++) begin
         // ack first so a stale flag cannot pass the checks
         wr(3'h4, 8'h50 | 8'(k), 1'b0);
         chk("irq cleared", 8'h00, irq);
         cnt(1'b0, n);
         chk("irq", 8'h01, irq);
         n = n - (32 << k);
         chk("period", 8'h01, n >= -5 && n <= 5);
         rd(3'h4, 8'h90 | 8'(k), "flag set");
         wr(3'h4, 8'h50 | 8'(k), 1'b0);
         rd(3'h4, 8'h10 | 8'(k), "flag acked");
      end
      wr(3'h4, 8'h00, 1'b0);
      cnt(1'b0, n);
      chk("irq masked", 8'h00, irq);
      rd(3'h4, 8'h80, "flag masked");
      run <= 1'b1;
      wr(3'h4, 8'h71, 1'b0);
      cnt(1'b0, n);
      // 256 edges of a 20 ns clock
      chk("ext divide", 8'h01, n >= 1000 && n <= 1050);
      chk("ext irq", 8'h01, irq);
      wr(3'h4, 8'h30, 1'b0);
      cnt(1'b0, n);
      chk("ext off", 8'h01, n >= 3000);
      run <= 1'b0;
      wr(3'h0, 8'h01, 1'b1);
      chk("debug force", 8'h01, dbgReq);
      chk("quiet cause", 8'h01, quiet);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(3'h1, 8'hc2, "options after reset");
      wr(3'h1, 8'h40, 1'b0);
      rd(3'h1, 8'h40, "options rewritten");
      @(posedge clk);
      portPinData <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("pin as port", 8'h00, {pinFn, pinOe_n});
      chk("port data", 8'h01, pinOut);
      cnt(1'b1, n);
      chk("watchdog off", 8'h01, n >= 3000);
      results();
   end
endmodule : system_options_and_periodic_wakeup_bench
